// >>> hdl/fcr_pkg.sv
// Constants, codes and carrier types for the flash configuration and flag registers.
// Assumes one core clock domain; the serial link is sampled, not clocked.
package fcr_pkg;

	localparam logic [7:0] CMD_WR_EN = 8'h06;
	localparam logic [7:0] CMD_WR_DIS = 8'h04;
	localparam logic [7:0] CMD_RD_EVCR = 8'h65;
	localparam logic [7:0] CMD_WR_EVCR = 8'h61;
	localparam logic [7:0] CMD_RD_FLAG = 8'h70;
	localparam logic [7:0] CMD_CLR_FLAG = 8'h50;

	localparam logic [7:0] EVCR_RST = 8'hDF;
	localparam logic [7:0] EVCR_RSVD_MASK = 8'hDF;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BW_EXT = 4'h1;
	localparam logic [3:0] BW_DUAL = 4'h2;
	localparam logic [3:0] BW_QUAD = 4'h4;
	localparam logic [3:0] OE_EXT = 4'h2;
	localparam logic [3:0] OE_DUAL = 4'h3;
	localparam logic [3:0] OE_QUAD = 4'hF;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		PROTO_EXT = 3'h1,
		PROTO_DUAL = 3'h2,
		PROTO_QUAD = 3'h4
	} fcr_proto_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CMD = 5'h02,
		ST_DIN = 5'h04,
		ST_OUT = 5'h08,
		ST_DONE = 5'h10
	} fcr_state_t;

	typedef struct packed {
		logic quad_n;
		logic dual_n;
		logic rsvd;
		logic hold_en;
		logic accel_n;
		logic [2:0] drive;
	} fcr_evcr_t;

	typedef struct packed {
		logic ready;
		logic erase_susp;
		logic erase_err;
		logic prog_err;
		logic vpp_err;
		logic prog_susp;
		logic prot_err;
		logic rsvd;
	} fcr_flag_t;

	typedef struct packed {
		logic busy;
		logic erase_susp;
		logic prog_susp;
		logic erase_fail;
		logic prog_fail;
		logic zero_to_one;
		logic vpp_bad;
		logic prot_err;
	} fcr_eng_t;

	typedef struct packed {
		fcr_proto_t proto;
		logic hold_en;
		logic accel_en;
		logic [2:0] drive;
	} fcr_cfg_t;

endpackage

// >>> hdl/fcr_sync.sv
// Two-stage synchroniser for levels entering the core clock domain.
// Assumes inputs are asynchronous to clk; only the second stage is read.
module fcr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk, // Core clock
	input wire logic resetn, // Async reset, active low
	input wire logic [W-1:0] d, // Asynchronous inputs
	output logic [W-1:0] q // Synchronised outputs
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= RST;
			q <= RST;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

// >>> hdl/fcr_flash_regs.sv
// Enhanced volatile configuration and flag registers behind the serial link.
// Assumes the link clock is far slower than ref_clk (sampled, edges detected)
// and that the array engine drives fcr_eng_t on ref_clk.
module fcr_flash_regs
	import fcr_pkg::*;
(
	input wire logic ref_clk, // Core clock, 250 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic sclk, // Link clock pin
	input wire logic cs_n, // Chip select pin, active low
	input wire logic [3:0] dq_in, // Data pins, input side
	output logic [3:0] dq_out, // Data pins, output side
	output logic [3:0] dq_oe, // Data pin drive enables
	input wire fcr_eng_t eng, // Array engine state and events
	output fcr_cfg_t cfg, // Active configuration
	output fcr_flag_t flag, // Flag register contents
	output logic err_pending, // An error bit is still set
	output logic wr_en_latch // Write enable latch
);

	////////////////////////////////////////////////////////////////////////
	// Pin sampling

	logic sclk_s, cs_n_s, sclk_d, cs_n_d;
	logic [3:0] dq_s;
	logic sclk_rise, sclk_fall, cs_rise;

	fcr_sync #(.W(6), .RST(6'h10)) u_sync (
		.clk(ref_clk),
		.resetn(resetn),
		.d({sclk, cs_n, dq_in}),
		.q({sclk_s, cs_n_s, dq_s})
	);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
	assign cs_rise = cs_n_s & ~cs_n_d;

	////////////////////////////////////////////////////////////////////////
	// Protocol width from the committed register

	fcr_evcr_t evcr_r;
	fcr_proto_t proto;
	logic [3:0] bw, oe_pat;
	logic [7:0] sh_in;

	always_comb begin
		if (!evcr_r.quad_n) begin
			proto = PROTO_QUAD;
		end else if (!evcr_r.dual_n) begin
			proto = PROTO_DUAL;
		end else begin
			proto = PROTO_EXT;
		end
	end

	always_comb begin
		case (proto)
			PROTO_QUAD: begin
				bw = BW_QUAD;
				oe_pat = OE_QUAD;
			end
			PROTO_DUAL: begin
				bw = BW_DUAL;
				oe_pat = OE_DUAL;
			end
			default: begin
				bw = BW_EXT;
				oe_pat = OE_EXT;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Frame state machine

	fcr_state_t st_r;
	logic [7:0] sh_r, cmd_r, din_r, out_sh_r;
	logic [3:0] cnt_r, cnt_sum;
	logic cmd_ok_r, din_ok_r, junk_r;
	fcr_flag_t flag_r;

	always_comb begin
		case (proto)
			PROTO_QUAD: sh_in = {sh_r[3:0], dq_s};
			PROTO_DUAL: sh_in = {sh_r[5:0], dq_s[1:0]};
			default: sh_in = {sh_r[6:0], dq_s[0]};
		endcase
	end

	assign cnt_sum = cnt_r + bw;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= ST_IDLE;
			sh_r <= 8'h00;
			cnt_r <= CNT_RST;
			cmd_r <= 8'h00;
			din_r <= 8'h00;
			cmd_ok_r <= 1'b0;
			din_ok_r <= 1'b0;
			junk_r <= 1'b0;
		end else if (cs_n_s) begin
			st_r <= ST_IDLE;
			cnt_r <= CNT_RST;
		end else begin
			case (st_r)
				ST_IDLE: begin
					st_r <= ST_CMD;
					cmd_ok_r <= 1'b0;
					din_ok_r <= 1'b0;
					junk_r <= 1'b0;
					cnt_r <= CNT_RST;
				end
				ST_CMD: begin
					if (sclk_rise) begin
						sh_r <= sh_in;
						cnt_r <= cnt_sum;
						if (cnt_sum == BITS_PER_BYTE) begin
							cmd_r <= sh_in;
							cmd_ok_r <= 1'b1;
							cnt_r <= CNT_RST;
							case (sh_in)
								CMD_RD_EVCR, CMD_RD_FLAG: st_r <= ST_OUT;
								CMD_WR_EVCR: st_r <= ST_DIN;
								default: st_r <= ST_DONE;
							endcase
						end
					end
				end
				ST_DIN: begin
					if (sclk_rise) begin
						sh_r <= sh_in;
						cnt_r <= cnt_sum;
						if (cnt_sum == BITS_PER_BYTE) begin
							din_r <= sh_in;
							din_ok_r <= 1'b1;
							st_r <= ST_DONE;
						end
					end
				end
				ST_OUT: begin
					if (sclk_fall) begin
						cnt_r <= (cnt_sum == BITS_PER_BYTE) ? CNT_RST : cnt_sum;
					end
				end
				ST_DONE: begin
					if (sclk_rise) begin
						junk_r <= 1'b1;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data path, shifted out on falling link clock edges

	logic [7:0] rd_byte;

	assign rd_byte = (cmd_r == CMD_RD_FLAG) ? flag_r : evcr_r;

	function automatic logic [3:0] lanes(input logic [7:0] b, input fcr_proto_t p);
		case (p)
			PROTO_QUAD: lanes = b[7:4];
			PROTO_DUAL: lanes = {2'b00, b[7:6]};
			default: lanes = {2'b00, b[7], 1'b0};
		endcase
	endfunction

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			out_sh_r <= 8'h00;
			dq_out <= 4'h0;
			dq_oe <= 4'h0;
		end else if (st_r != ST_OUT || cs_n_s) begin
			dq_oe <= 4'h0;
			dq_out <= 4'h0;
		end else if (sclk_fall) begin
			dq_oe <= oe_pat;
			if (cnt_r == CNT_RST) begin
				// Fresh snapshot per byte so live status bits stay current
				dq_out <= lanes(rd_byte, proto);
				out_sh_r <= rd_byte << bw;
			end else begin
				dq_out <= lanes(out_sh_r, proto);
				out_sh_r <= out_sh_r << bw;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Commands committed at chip select rise

	logic frame_ok, wr_go, clr_go;

	assign frame_ok = cs_rise & cmd_ok_r & ~junk_r;
	assign wr_go = frame_ok & din_ok_r & (cmd_r == CMD_WR_EVCR) & wr_en_latch;
	assign clr_go = frame_ok & ~din_ok_r & (cmd_r == CMD_CLR_FLAG);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_en_latch <= 1'b0;
		end else if (frame_ok && cmd_r == CMD_WR_EN) begin
			wr_en_latch <= 1'b1;
		end else if (frame_ok && (cmd_r == CMD_WR_DIS || wr_go)) begin
			wr_en_latch <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			evcr_r <= EVCR_RST;
		end else if (wr_go) begin
			// Only between frames, so width never flips mid-transfer
			evcr_r <= din_r & EVCR_RSVD_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg <= '{proto: PROTO_EXT, hold_en: 1'b1, accel_en: 1'b0, drive: 3'h7};
		end else begin
			cfg.proto <= proto;
			cfg.hold_en <= evcr_r.hold_en;
			cfg.accel_en <= ~evcr_r.accel_n;
			cfg.drive <= evcr_r.drive;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag register: live status, sticky errors, set beats clear

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flag_r <= '{ready: 1'b1, default: 1'b0};
		end else begin
			flag_r.ready <= ~eng.busy;
			flag_r.erase_susp <= eng.erase_susp;
			flag_r.prog_susp <= eng.prog_susp;
			flag_r.erase_err <= (flag_r.erase_err & ~clr_go) | eng.erase_fail;
			flag_r.prog_err <= (flag_r.prog_err & ~clr_go) | eng.prog_fail
				| eng.zero_to_one;
			flag_r.vpp_err <= (flag_r.vpp_err & ~clr_go) | eng.vpp_bad;
			flag_r.prot_err <= (flag_r.prot_err & ~clr_go) | eng.prot_err;
			flag_r.rsvd <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			err_pending <= 1'b0;
		end else begin
			// Engine may fail new commands while this is high
			err_pending <= flag_r.erase_err | flag_r.prog_err | flag_r.vpp_err
				| flag_r.prot_err;
		end
	end

	assign flag = flag_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	property p_quad_sel;
		!evcr_r.quad_n |-> ##1 cfg.proto == PROTO_QUAD;
	endproperty
	a_quad_sel: assert property (p_quad_sel) else $error("quad not selected");

	property p_cfg_at_cs;
		$changed(evcr_r) |-> $past(cs_rise) && !$past(cs_n_d);
	endproperty
	a_cfg_at_cs: assert property (p_cfg_at_cs) else $error("config changed mid frame");

	property p_wr_needs_wel;
		(cs_rise && cmd_r == CMD_WR_EVCR && !wr_en_latch) |=> $stable(evcr_r);
	endproperty
	a_wr_needs_wel: assert property (p_wr_needs_wel) else $error("write without enable");

	property p_err_sticky;
		$fell(flag_r.erase_err) |-> $past(clr_go) && $past(cmd_r) == CMD_CLR_FLAG;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error bit fell uncleared");

	property p_erase_err_set;
		eng.erase_fail |=> flag_r.erase_err ##1 flag_r.erase_err || $past(clr_go);
	endproperty
	a_erase_err_set: assert property (p_erase_err_set) else $error("erase error lost");

	property p_busy;
		eng.busy |=> !flag_r.ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready shown while busy");

	property p_oe_read;
		dq_oe != 4'h0 |-> st_r == ST_OUT && (cmd_r == CMD_RD_EVCR || cmd_r == CMD_RD_FLAG);
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("drive outside read");

	property p_clr_set_wins;
		(clr_go && eng.prog_fail) |=> flag_r.prog_err;
	endproperty
	a_clr_set_wins: assert property (p_clr_set_wins) else $error("set lost to clear");

	property p_susp_track;
		eng.erase_susp ##1 !eng.erase_susp |=> !flag_r.erase_susp;
	endproperty
	a_susp_track: assert property (p_susp_track) else $error("suspend not auto clear");

endmodule

// >>> testbench/fcr_spi_host.sv
// Behavioural serial host for the flag and config block, link mode 0.
// Assumes ref_clk is the bench clock; half a link period is 8 of its cycles.
module fcr_spi_host
	import fcr_pkg::*;
(
	input wire logic ref_clk, // Bench clock
	input wire logic [3:0] dq_out, // Device data out
	input wire logic [3:0] dq_oe, // Device drive enables
	output logic sclk, // Link clock, idle low
	output logic cs_n, // Chip select
	output logic [3:0] dq_in // Device data in
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] oe_seen = 4'h0;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dq_in = 4'h5;
	end

	// Slow link clock suits any dummy-cycle count
	task automatic half();
		repeat (8) @(posedge ref_clk);
		#1;
	endtask

	// Idle lines toggle each bit, so a stale level never passes for data
	task automatic frame(input logic [15:0] tx, input int ntx, input int nrx, input int bw,
		output logic [7:0] rx);
		logic [19:0] t;
		logic [3:0] m;
		logic [3:0] d;
		rx = 8'h00;
		t = {tx, 4'h0};
		m = 4'((1 << bw) - 1);
		cs_n = 1'b0;
		for (int k = 0; k < ntx + nrx; k += bw) begin
			d = ~dq_in;
			if (k < ntx) begin
				d = (d & ~m) | ((t[19-k -: 4] >> (4 - bw)) & m);
			end
			dq_in = d;
			half();
			if (k >= ntx) begin
				rx = (rx << bw) | {4'h0, (bw == 1) ? {3'h0, dq_out[1]} : (dq_out & m)};
				oe_seen = dq_oe;
			end
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
		half();
		cs_n = 1'b1;
		half();
	endtask

	////////////////////////////////////////
	task automatic wr_cfg(input logic [7:0] d, input int bw);
		logic [7:0] r;
		frame({CMD_WR_EN, 8'h00}, 8, 0, bw, r);
		frame({CMD_WR_EVCR, d}, 16, 0, bw, r);
	endtask

	task automatic clr(input int bw);
		logic [7:0] r;
		frame({CMD_CLR_FLAG, 8'h00}, 8, 0, bw, r);
	endtask
endmodule

// >>> testbench/tb_fcr_flash_regs.sv
// Self-checking bench for the flag and enhanced configuration registers.
// Assumes the host model drives the link; engine events are driven here.
module tb_fcr_flash_regs
	import fcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	fcr_eng_t eng = '0;
	logic sclk;
	logic cs_n;
	logic [3:0] dq_in;
	logic [3:0] dq_out;
	logic [3:0] dq_oe;
	fcr_cfg_t cfg;
	fcr_flag_t flag;
	logic err_pending;
	logic wr_en_latch;
	logic [7:0] exp_q[$];
	logic [7:0] res_v;
	logic [7:0] exp_v;
	logic [7:0] r;
	logic [7:0] ev_flag[5] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h02};
	logic [31:0] lfsr_r = 32'h4E88F8F3;
	event res_ev;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #2 ref_clk = ~ref_clk;

	fcr_flash_regs dut (.ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .eng(eng), .cfg(cfg), .flag(flag),
		.err_pending(err_pending), .wr_en_latch(wr_en_latch));
	fcr_spi_host host (.ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe), .sclk(sclk),
		.cs_n(cs_n), .dq_in(dq_in));

	////////////////////////////////////////
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			results();
		end
	end

	initial forever begin
		@res_ev;
		// Pop once; the macro names its expected value twice
		exp_v = exp_q.pop_front();
		`CHK(res_v, exp_v)
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] cfg_of(input logic [7:0] d);
		fcr_proto_t p;
		p = !d[7] ? PROTO_QUAD : (!d[6] ? PROTO_DUAL : PROTO_EXT);
		return {p, d[4], !d[3], d[2:0]};
	endfunction

	function automatic logic [3:0] oe_of(input int bw);
		return (bw == 4) ? OE_QUAD : ((bw == 2) ? OE_DUAL : OE_EXT);
	endfunction

	task automatic note(input logic [7:0] v);
		exp_q.push_back(v);
	endtask

	// Resync to the drive slot so later stimulus keeps its offset
	task automatic got(input logic [7:0] v);
		res_v = v;
		->res_ev;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] cmd, input int bw);
		logic [7:0] q;
		host.frame({cmd, 8'h00}, 8, 8, bw, q);
		got(q);
		note({4'h0, oe_of(bw)});
		got({4'h0, host.oe_seen});
		note(8'h00);
		got({4'h0, dq_oe});
	endtask

	// Write in one width, read back in the width the new value selects
	task automatic wcheck(input logic [7:0] d, input int bw, input int nbw);
		host.wr_cfg(d, bw);
		note(8'h00);
		got({7'h0, wr_en_latch});
		note(d & 8'hDF);
		rd(CMD_RD_EVCR, nbw);
		note(cfg_of(d));
		got(cfg);
	endtask

	task automatic eng_set(input fcr_eng_t e);
		@(posedge ref_clk);
		#1;
		eng = e;
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		note(8'h80);
		rd(CMD_RD_FLAG, 1);
		note(8'hDF);
		rd(CMD_RD_EVCR, 1);
		note({PROTO_EXT, 1'b1, 1'b0, 3'h7});
		got(cfg);
		host.frame({CMD_WR_EN, 8'h00}, 8, 0, 1, r);
		note(8'h01);
		got({7'h0, wr_en_latch});
		host.frame({CMD_WR_DIS, 8'h00}, 8, 0, 1, r);
		note(8'h00);
		got({7'h0, wr_en_latch});
		host.frame({CMD_WR_EVCR, 8'h55}, 16, 0, 1, r);
		note(8'hDF);
		rd(CMD_RD_EVCR, 1);
		$display("reset values and refused write done");
		for (int i = 0; i < 8; i++) begin
			lfsr_r = lfsr(lfsr_r);
			wcheck({2'b11, lfsr_r[2:0], 3'(i)}, 1, 1);
		end
		wcheck(8'hBF, 1, 2);
		wcheck(8'h3F, 2, 4);
		wcheck(8'h7F, 4, 4);
		wcheck(8'hDF, 4, 1);
		$display("config writes and widths done");
		eng_set('{busy: 1'b1, erase_susp: 1'b1, prog_susp: 1'b1, default: 1'b0});
		note(8'h44);
		rd(CMD_RD_FLAG, 1);
		note(8'h44);
		got(flag);
		eng_set('0);
		note(8'h80);
		rd(CMD_RD_FLAG, 1);
		for (int i = 0; i < 5; i++) begin
			eng_set(fcr_eng_t'(8'h10 >> i));
			eng_set('0);
			note(8'h80 | ev_flag[i]);
			rd(CMD_RD_FLAG, 1);
			note(8'h01);
			got({7'h0, err_pending});
			host.clr(1);
			note(8'h80);
			rd(CMD_RD_FLAG, 1);
			note(8'h00);
			got({7'h0, err_pending});
		end
		// Failure held through a clear: set must win
		eng_set('{prog_fail: 1'b1, default: 1'b0});
		host.clr(1);
		eng_set('0);
		note(8'h90);
		rd(CMD_RD_FLAG, 1);
		host.clr(1);
		eng_set(fcr_eng_t'(8'h01));
		eng_set('0);
		host.frame({CMD_CLR_FLAG, 8'h00}, 12, 0, 1, r);
		note(8'h82);
		rd(CMD_RD_FLAG, 1);
		host.clr(1);
		note(8'h80);
		rd(CMD_RD_FLAG, 1);
		$display("flag events and clears done");
		results();
	end
endmodule
